/* logic/adsd_params.svh */
// Register offsets, control bit positions, reset values and counts of the sample demultiplexer
`ifndef ADSD_PARAMS_SVH
`define ADSD_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define ADSD_CTRL_OFFS   4'h0
`define ADSD_STAT_OFFS   4'h4
`define ADSD_CNT_OFFS    4'h8

// Control register bit positions
`define ADSD_CTRL_MRST   0
`define ADSD_CTRL_RATIO  1
`define ADSD_CTRL_ICLK   2
`define ADSD_CTRL_OCLK   3
`define ADSD_CTRL_STGN   4
`define ADSD_CTRL_SLPN   5
`define ADSD_CTRL_DCEN   6
`define ADSD_CTRL_BSTN   7

// Every control bit idles high, as an open pin would read
`define ADSD_CTRL_RST    8'hff

// Status register bit positions
`define ADSD_STAT_SLOT   0
`define ADSD_STAT_MRST   2
`define ADSD_STAT_CLK    3
`define ADSD_STAT_SLEEP  4

// Pin synchroniser depth and output port count
`define ADSD_SYNC_STAGES 2
`define ADSD_PORTS       4

`endif

/* logic/adsd_pkg.sv */
// Types shared by the sample demultiplexer
package adsd_pkg;

  typedef logic [9:0]  adsd_word_t;
  typedef logic [1:0]  adsd_slot_t;
  typedef logic [7:0]  adsd_ctrl_t;
  typedef logic [15:0] adsd_count_t;

  typedef enum logic {
    ADSD_RATIO_2 = 1'b0,
    ADSD_RATIO_4 = 1'b1
  } adsd_ratio_e;

endpackage : adsd_pkg

/* logic/adsd_stream_demux.sv */
// Sample stream demultiplexer 1:2 / 1:4 with Wishbone control and status
//
// Summary of operation
// - Ratio select low splits samples over two ports, high over four ports.
// - In two-way ratio ports C and D carry no valid data.
// - Four-way ratio spreads the extra bit over all four ports' extra outputs.
// - Two-way ratio spreads the extra bit over ports A and B only.
// - Staggered mode puts each port's ready clock on its extra-bit output.
// - Input clock type 0 is single-edge, 1 is dual-edge.
// - Output clock type 1 gives single-edge ready clock, 0 dual-edge.
// - Single-edge: rising edges only, clock rate equals data rate.
// - Dual-edge: both edges active, clock rate is half the data rate.
// - Input and output clock types are chosen independently.
// - Input clock type defaults to dual-edge when left open.
// - Four-way ratio: ready clock and data toggle at quarter input rate.
// - Staggered select high or open presents all ports together.
// - Staggered select low presents port packets one after another.
// - Sleep, delay enable, staggered select, self test are active low, idle high.
// - Master reset is active high, asserted when open, low releases it.
// - Sleep freezes all outputs at fixed valid levels.
// - Delay-cell input reaches its output only while the enable is asserted.
// - One master reset keeps ports phase aligned forever, no resync.
// - Staggered mode offsets successive ports by one input sample: half an output period at 1:2, a quarter at 1:4.
// - Self test toggles every data bit of the active ports once per input sample.
`timescale 1ns/1ps
`include "adsd_params.svh"

module adsd_stream_demux #(
  parameter int unsigned AW = 4
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [AW-1:0]      wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               input_clock_i,
  input  wire adsd_pkg::adsd_word_t sample_data_i,
  input  wire logic               extra_input_bit_i,
  input  wire logic               delay_cell_in_i,
  output adsd_pkg::adsd_word_t    port_a_data_o,
  output adsd_pkg::adsd_word_t    port_b_data_o,
  output adsd_pkg::adsd_word_t    port_c_data_o,
  output adsd_pkg::adsd_word_t    port_d_data_o,
  output logic                    port_a_extra_bit_o,
  output logic                    port_b_extra_bit_o,
  output logic                    port_c_extra_bit_o,
  output logic                    port_d_extra_bit_o,
  output logic                    data_ready_out_clock_o,
  output logic                    delay_cell_out_o
);
  import adsd_pkg::*;

  localparam int unsigned NP = `ADSD_PORTS;
  localparam int unsigned SW = 13;

  // Control and decoded mode bits
  adsd_ctrl_t  ctrl_r;
  adsd_count_t word_cnt_r;
  logic        ack_r;
  logic [31:0] dat_r;

  wire master_reset      = ctrl_r[`ADSD_CTRL_MRST];
  wire ratio_select      = ctrl_r[`ADSD_CTRL_RATIO];
  wire input_clock_type  = ctrl_r[`ADSD_CTRL_ICLK];
  wire output_clock_type = ctrl_r[`ADSD_CTRL_OCLK];
  wire staggered         = ~ctrl_r[`ADSD_CTRL_STGN];
  wire sleep_act         = ~ctrl_r[`ADSD_CTRL_SLPN];
  wire delay_cell_enable = ~ctrl_r[`ADSD_CTRL_DCEN];
  wire self_test_act     = ~ctrl_r[`ADSD_CTRL_BSTN];
  wire dual_edge_output_mode = ~output_clock_type;
  wire run_lock          = master_reset | ~rst_n_i;

  // Pin synchronisers: the first stage feeds only the second
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic          clk_d_r;
  wire  [SW-1:0] pins_async = {delay_cell_in_i, extra_input_bit_i, sample_data_i, input_clock_i};

  always_ff @(posedge clk_sys_i) begin
    sync1_r <= pins_async;
    sync2_r <= sync1_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (run_lock) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= sync2_r[0];
    end
  end

  wire        clk_lvl    = sync2_r[0];
  adsd_word_t samp_w;
  assign samp_w = sync2_r[10:1];
  wire        xbit_w     = sync2_r[11];
  wire        dci_w      = sync2_r[12];

  // Edge detection on the sampled link clock
  wire clk_rise = clk_lvl & ~clk_d_r;
  wire clk_fall = ~clk_lvl & clk_d_r;
  // Data is taken in the same cycle as the edge, so both paths see equal latency
  wire edge_hit = clk_rise | (input_clock_type & clk_fall);
  wire strobe   = edge_hit & ~sleep_act & ~run_lock;

  // Slot rotation over the active ports
  adsd_slot_t slot_r;
  adsd_slot_t last_slot;
  adsd_slot_t half_slot;
  adsd_slot_t slot_nxt;

  assign last_slot = (ratio_select == ADSD_RATIO_4) ? 2'h3 : 2'h1;
  assign half_slot = (ratio_select == ADSD_RATIO_4) ? 2'h2 : 2'h1;
  assign slot_nxt  = (slot_r == last_slot) ? 2'h0 : slot_r + 2'h1;

  // Counter is never cleared by data, so alignment holds after one reset
  always_ff @(posedge clk_sys_i) begin
    if (run_lock) begin
      slot_r <= 2'h0;
    end else if (strobe) begin
      slot_r <= slot_nxt;
    end
  end

  wire group_done = strobe & (slot_r == last_slot);
  wire group_half = strobe & (slot_r == (half_slot - 2'h1));

  // Per-port capture, output and ready clock
  adsd_word_t hold_r [NP];
  adsd_word_t out_r  [NP];
  logic [NP-1:0] xhold_r;
  logic [NP-1:0] xout_r;
  logic [NP-1:0] rdy_r;

  genvar k;
  generate
    for (k = 0; k < NP; k = k + 1) begin : g_port
      wire adsd_slot_t kk = 2'(k);
      wire active   = (kk <= last_slot);
      wire own_slot = (slot_r == kk);
      wire upd_slot = staggered ? own_slot : (slot_r == last_slot);
      wire upd      = strobe & active & upd_slot;
      wire adsd_slot_t clr_slot = staggered ? ((kk + half_slot) & last_slot) : (half_slot - 2'h1);
      wire clr      = strobe & active & (slot_r == clr_slot);
      wire adsd_word_t dsel = own_slot ? samp_w : hold_r[k];
      wire xsel     = own_slot ? xbit_w : xhold_r[k];
      wire rdy_nxt;
      wire xdat_nxt;
      wire adsd_word_t dat_nxt;

      // Dual-edge toggles once per word; single-edge rises per word, falls mid-word
      assign rdy_nxt = upd ? (dual_edge_output_mode ? ~rdy_r[k] : 1'b1) :
                       ((clr & output_clock_type) ? 1'b0 : rdy_r[k]);
      assign dat_nxt = self_test_act ? (strobe & active ? ~out_r[k] : out_r[k]) :
                       (upd ? dsel : out_r[k]);
      assign xdat_nxt = self_test_act ? (strobe & active ? ~xout_r[k] : xout_r[k]) :
                        (upd ? xsel : xout_r[k]);

      always_ff @(posedge clk_sys_i) begin
        if (run_lock) begin
          hold_r[k]  <= '0;
          xhold_r[k] <= 1'b0;
        end else if (strobe & own_slot) begin
          hold_r[k]  <= samp_w;
          xhold_r[k] <= xbit_w;
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (run_lock) begin
          out_r[k] <= '0;
          rdy_r[k] <= 1'b0;
        end else begin
          out_r[k] <= dat_nxt;
          rdy_r[k] <= rdy_nxt;
        end
      end

      // Extra-bit pin doubles as the port clock in staggered mode
      always_ff @(posedge clk_sys_i) begin
        if (run_lock) begin
          xout_r[k] <= 1'b0;
        end else begin
          xout_r[k] <= staggered ? rdy_nxt : xdat_nxt;
        end
      end
    end
  endgenerate

  assign port_a_data_o      = out_r[0];
  assign port_b_data_o      = out_r[1];
  assign port_c_data_o      = out_r[2];
  assign port_d_data_o      = out_r[3];
  assign port_a_extra_bit_o = xout_r[0];
  assign port_b_extra_bit_o = xout_r[1];
  assign port_c_extra_bit_o = xout_r[2];
  assign port_d_extra_bit_o = xout_r[3];

  // Common ready clock follows the simultaneous word boundary
  logic drdy_r;
  wire  drdy_nxt = group_done ? (dual_edge_output_mode ? ~drdy_r : 1'b1) :
                   ((group_half & output_clock_type) ? 1'b0 : drdy_r);

  always_ff @(posedge clk_sys_i) begin
    if (run_lock) begin
      drdy_r <= 1'b0;
    end else begin
      drdy_r <= drdy_nxt;
    end
  end

  assign data_ready_out_clock_o = drdy_r;

  // Delay cell: logic path only, the analog tuning has no model here
  logic dco_r;
  wire  dco_nxt = sleep_act ? dco_r : (delay_cell_enable & dci_w);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dco_r <= 1'b0;
    end else begin
      dco_r <= dco_nxt;
    end
  end

  assign delay_cell_out_o = dco_r;

  // Completed words, wraps silently
  always_ff @(posedge clk_sys_i) begin
    if (run_lock) begin
      word_cnt_r <= '0;
    end else if (group_done) begin
      word_cnt_r <= word_cnt_r + 16'h0001;
    end
  end

  // Wishbone classic slave, one wait state, unmapped reads return zero
  wire req       = wb_cyc_i & wb_stb_i;
  wire take      = req & ~ack_r;
  wire hit_ctrl  = (wb_adr_i == `ADSD_CTRL_OFFS);
  wire hit_stat  = (wb_adr_i == `ADSD_STAT_OFFS);
  wire hit_cnt   = (wb_adr_i == `ADSD_CNT_OFFS);
  // Write lands on the edge where the master samples ack
  wire ctrl_wr   = req & ack_r & wb_we_i & hit_ctrl & wb_sel_i[0];

  wire [31:0] stat_word = {27'h0000000,
                           sleep_act,
                           clk_lvl,
                           master_reset,
                           slot_r};
  wire [31:0] rd_word   = hit_ctrl ? {24'h000000, ctrl_r} :
                          hit_stat ? stat_word :
                          hit_cnt  ? {16'h0000, word_cnt_r} : 32'h00000000;

  // Reset reads as asserted and all modes idle inactive until written
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `ADSD_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dat_r <= 32'h00000000;
    end else if (take) begin
      dat_r <= rd_word;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule : adsd_stream_demux

/* dv/adsd_sva.sv */
// Port checker of the sample demultiplexer
`timescale 1ns/1ps
module adsd_sva (
  input wire logic                 clk_sys_i,
  input wire logic                 rst_n_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 input_clock_i,
  input wire logic                 delay_cell_in_i,
  input wire logic                 delay_cell_out_o,
  input wire adsd_pkg::adsd_word_t port_a_data_o,
  input wire adsd_pkg::adsd_word_t port_d_data_o,
  input wire logic                 port_a_extra_bit_o,
  input wire logic                 port_d_extra_bit_o,
  input wire logic                 data_ready_out_clock_o
);
  import adsd_pkg::*;
  logic       link_r;
  logic [3:0] quiet_r;
  // Cycles since a link edge or a bus answer; outputs may only move shortly after one
  wire        kick = wb_ack_o || (input_clock_i != link_r);
  always_ff @(posedge clk_sys_i) begin
    link_r <= input_clock_i;
    quiet_r <= (!rst_n_i || kick) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_rdata_cause: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("read data moved without request");
  a_delay_off: assert property (!delay_cell_in_i [*4] |=> !delay_cell_out_o)
    else $error("delay output high with input low");
  a_port_a_quiet: assert property ($changed(port_a_data_o) |-> quiet_r < 4'h6)
    else $error("port a moved without link edge");
  a_port_d_quiet: assert property ($changed(port_d_data_o) |-> quiet_r < 4'h6)
    else $error("port d moved without link edge");
  a_ready_quiet: assert property ($changed(data_ready_out_clock_o) |-> quiet_r <= 4'h5)
    else $error("ready clock moved without link edge");
  a_extra_quiet: assert property ($changed(port_a_extra_bit_o) || $changed(port_d_extra_bit_o) |-> quiet_r < 4'h6)
    else $error("extra bit moved without link edge");
  c_ready_rise: cover property ($rose(data_ready_out_clock_o));
  c_port_d: cover property ($changed(port_d_data_o));
  c_stag_clk: cover property ($rose(port_a_extra_bit_o));
endmodule : adsd_sva
bind adsd_stream_demux adsd_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .input_clock_i(input_clock_i),
  .delay_cell_in_i(delay_cell_in_i), .delay_cell_out_o(delay_cell_out_o), .port_a_data_o(port_a_data_o),
  .port_d_data_o(port_d_data_o), .port_a_extra_bit_o(port_a_extra_bit_o),
  .port_d_extra_bit_o(port_d_extra_bit_o), .data_ready_out_clock_o(data_ready_out_clock_o));

/* dv/adsd_link_src.sv */
// Converter side model: sample clock, sample word and extra bit
`timescale 1ns/1ps
module adsd_link_src (
  output logic                 lclk_o,
  output adsd_pkg::adsd_word_t word_o,
  output logic                 extra_o
);
  import adsd_pkg::*;
  initial begin
    lclk_o = 1'b0;
    word_o = 10'h155;
    extra_o = 1'b0;
  end
  // One 800 ns period per sample, offset from the system clock; data settles 400 ns before the edge
  task automatic send(input adsd_word_t w, input logic dual);
    #37;
    word_o = w;
    extra_o = w[0];
    #400;
    lclk_o = dual ? !lclk_o : 1'b1;
    #350;
    if (!dual) lclk_o = 1'b0;
    word_o = ~word_o;
    extra_o = ~extra_o;
    // Returns one link period later, on a system edge, so the next sample keeps the 800 ns pace
    #13;
  endtask : send
endmodule : adsd_link_src

/* dv/tb_top.sv */
// Self-checking bench of the sample demultiplexer
`timescale 1ns/1ps
`include "adsd_params.svh"
module tb_top;
  import adsd_pkg::*;
  logic        clk_sys_i, rst_n_i, cyc, we, ack, dci, dco, lclk, extra, xa, xb, xc, xd, rdy;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat;
  adsd_word_t  word, pa, pb, pc, pd;
  int          error_cnt, n_checks;
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  adsd_link_src LNK (.lclk_o(lclk), .word_o(word), .extra_o(extra));
  adsd_stream_demux DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .input_clock_i(lclk), .sample_data_i(word), .extra_input_bit_i(extra), .delay_cell_in_i(dci),
    .port_a_data_o(pa), .port_b_data_o(pb), .port_c_data_o(pc), .port_d_data_o(pd),
    .port_a_extra_bit_o(xa), .port_b_extra_bit_o(xb), .port_c_extra_bit_o(xc),
    .port_d_extra_bit_o(xd), .data_ready_out_clock_o(rdy), .delay_cell_out_o(dco));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // Ack is read right after the edge, before that edge's updates land
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    i = 0;
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    cyc <= 1'b0;
    if (i >= 20) begin
      error_cnt++;
      complete_run();
    end
  endtask : wb
  task automatic wr(input logic [7:0] c);
    logic [31:0] q;
    wb(1'b1, `ADSD_CTRL_OFFS, {24'h0, c}, q);
  endtask : wr
  // Modes change only while the demux is held in master reset
  task automatic mode(input logic [7:0] c);
    wr(c | 8'h01);
    wr(c);
  endtask : mode
  task automatic tx(input adsd_word_t w, input logic d);
    LNK.send(w, d);
  endtask : tx
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, `ADSD_CTRL_OFFS, 32'h0, q);
    check("ctrl", 32'hff, q);
    wb(1'b0, `ADSD_STAT_OFFS, 32'h0, q);
    check("stat mrst", 32'h1, 32'(q[`ADSD_STAT_MRST]));
    wb(1'b1, 4'hc, 32'hff, q);
    wb(1'b0, 4'hc, 32'h0, q);
    check("unmapped", 32'h0, q);
    $display("test regs done");
  endtask : t_regs
  task automatic t_quad();
    adsd_word_t w[4] = '{10'h101, 10'h202, 10'h303, 10'h0f4};
    mode(8'hfa);
    foreach (w[i]) tx(w[i], 1'b0);
    check("a", 32'h101, 32'(pa));
    check("d", 32'h0f4, 32'(pd));
    check("xc", 32'h1, 32'(xc));
    check("rdy", 32'h1, 32'(rdy));
    tx(10'h011, 1'b0);
    tx(10'h022, 1'b0);
    check("rdy fall", 32'h0, 32'(rdy));
    check("a held", 32'h101, 32'(pa));
    $display("test quad done");
  endtask : t_quad
  task automatic t_pair();
    mode(8'hf4);
    tx(10'h2aa, 1'b1);
    tx(10'h155, 1'b1);
    check("b", 32'h155, 32'(pb));
    check("xb", 32'h1, 32'(xb));
    check("c", 32'h0, 32'(pc));
    check("rdy", 32'h1, 32'(rdy));
    tx(10'h0c3, 1'b1);
    tx(10'h03c, 1'b1);
    check("a", 32'h0c3, 32'(pa));
    check("rdy", 32'h0, 32'(rdy));
    $display("test pair done");
  endtask : t_pair
  task automatic t_stag();
    mode(8'he4);
    tx(10'h3c0, 1'b1);
    check("a", 32'h3c0, 32'(pa));
    check("b early", 32'h0, 32'(pb));
    check("xa clk", 32'h1, 32'(xa));
    tx(10'h0c0, 1'b1);
    check("xb clk", 32'h1, 32'(xb));
    $display("test stag done");
  endtask : t_stag
  // Staggered 1:4 with single-edge input and dual-edge ready clock
  task automatic t_stag4();
    mode(8'he2);
    tx(10'h111, 1'b0);
    tx(10'h222, 1'b0);
    tx(10'h333, 1'b0);
    check("c own", 32'h333, 32'(pc));
    check("d early", 32'h0, 32'(pd));
    check("xc clk", 32'h1, 32'(xc));
    tx(10'h044, 1'b0);
    check("d own", 32'h044, 32'(pd));
    check("xd clk", 32'h1, 32'(xd));
    $display("test stag4 done");
  endtask : t_stag4
  task automatic t_test();
    mode(8'h7a);
    tx(10'h000, 1'b0);
    check("test a", 32'h3ff, 32'(pa));
    check("test d", 32'h3ff, 32'(pd));
    wr(8'h5a);
    tx(10'h000, 1'b0);
    check("sleep a", 32'h3ff, 32'(pa));
    $display("test selftest done");
  endtask : t_test
  task automatic t_delay();
    mode(8'hba);
    dci <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check("dly on", 32'h1, 32'(dco));
    wr(8'hfa);
    repeat (5) @(posedge clk_sys_i);
    check("dly off", 32'h0, 32'(dco));
    dci <= 1'b0;
    $display("test delay done");
  endtask : t_delay
  initial begin
    rst_n_i = 1'b0;
    {cyc, we, dci, adr, sel, wdat} = '0;
    error_cnt = 0;
    n_checks = 0;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_regs();
    t_quad();
    t_pair();
    t_stag();
    t_stag4();
    t_test();
    t_delay();
    complete_run();
  end
endmodule : tb_top
